// [rtl/opsel_cmp.sv]
// Threshold comparator for one input detector
`timescale 1ns/100ps
`include "opsel_params.svh"
module opsel_cmp #(
   parameter int PWR_W = `OPSEL_PWR_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Levels
   input wire logic [PWR_W-1:0] level,
   input wire logic [PWR_W-1:0] thresh,
   // Result
   output logic above_reg
);
   // Strictly above the threshold
   wire logic above_next = level > thresh;
   always_ff @(posedge mclk) begin
      if (!nrst) above_reg <= 1'b0;
      else above_reg <= above_next;
   end
endmodule : opsel_cmp

// [rtl/opsel_params.svh]
// Constants for the optical path protection selector
`ifndef OPSEL_PARAMS_SVH
`define OPSEL_PARAMS_SVH
// Power readout width in bits
`define OPSEL_PWR_W 12
// Readout code for 2.0 V, the 0 dBm point, at 1 mV per code
`define OPSEL_CODE_0DBM 12'h7d0
// Revert hold time in ms and the cycles it takes at 25 MHz
`define OPSEL_REVERT_MS 1000
`define OPSEL_CLK_HZ 25000000
`define OPSEL_REVERT_CYC ((`OPSEL_CLK_HZ / 1000) * `OPSEL_REVERT_MS)
// Selector position codes
`define OPSEL_POS_AUTO 2'h0
`define OPSEL_POS_LEFT 2'h1
`define OPSEL_POS_RIGHT 2'h2
`endif

// [rtl/opsel_pkg.sv]
// Types for the optical path protection selector
package opsel_pkg;
   // Tri-colour lamp drive, one-hot
   typedef struct packed {
      logic red;
      logic yellow;
      logic green;
   } opsel_lamp_s;
   // Path selection state
   typedef enum logic [1:0] {
      OPSEL_ON_MAIN = 2'b01,
      OPSEL_ON_BACKUP = 2'b10
   } opsel_path_e;
endpackage : opsel_pkg

// [rtl/opsel_timer.sv]
// Revert hold timer
`timescale 1ns/100ps
`include "opsel_params.svh"
module opsel_timer #(
   parameter int HOLD_CYC = `OPSEL_REVERT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Condition to time
   input wire logic run,
   // Expiry level
   output logic done_reg
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   // Refuse a hold time the counter cannot serve
   if (HOLD_CYC < 1) begin : g_bad_hold
      $error("HOLD_CYC must be at least 1");
   end
   logic [CW-1:0] cnt_reg;
   wire logic at_end = cnt_reg == CW'(HOLD_CYC);
   always_ff @(posedge mclk) begin
      if (!nrst || !run) begin
         cnt_reg <= '0;
         done_reg <= 1'b0;
      end else if (!at_end) begin
         cnt_reg <= cnt_reg + CW'(1);
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b1;
      end
   end
endmodule : opsel_timer

// [rtl/opsel_top.sv]
// Optical path protection selector control logic
`timescale 1ns/100ps
`include "opsel_params.svh"
module opsel_top #(
   parameter int PWR_W = `OPSEL_PWR_W,
   parameter int REVERT_CYC = `OPSEL_REVERT_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Directional input detectors, 1 mV per code
   input wire logic [PWR_W-1:0] main_path_pwr,
   input wire logic [PWR_W-1:0] backup_path_pwr,
   // Threshold set point and its valid flag
   input wire logic [PWR_W-1:0] thresh_set,
   input wire logic thresh_adjusted,
   // Selector position
   input wire logic [1:0] sel_pos,
   // Fault inputs
   input wire logic switch_fail,
   input wire logic temp_alarm,
   // Optical switch drive, high selects backup
   output logic path_backup_reg,
   // Status and input lamps
   output opsel_pkg::opsel_lamp_s stat_lamp_reg,
   output opsel_pkg::opsel_lamp_s main_lamp_reg,
   output opsel_pkg::opsel_lamp_s backup_lamp_reg,
   // Position lamps
   output logic auto_lamp_reg,
   output logic main_pos_lamp_reg,
   output logic backup_pos_lamp_reg,
   // Monitor readouts
   output logic [PWR_W-1:0] main_mon_reg,
   output logic [PWR_W-1:0] backup_mon_reg,
   output logic [PWR_W-1:0] thresh_mon_reg
);
   // Refuse a readout too narrow for the default threshold code
   if (PWR_W < 12) begin : g_bad_width
      $error("PWR_W must be at least 12");
   end

   opsel_pkg::opsel_path_e path_reg;
   opsel_pkg::opsel_path_e path_next;
   logic main_ok;
   logic backup_ok;
   logic revert_done;

   wire logic [PWR_W-1:0] thresh = thresh_adjusted ? thresh_set : PWR_W'(`OPSEL_CODE_0DBM);

   opsel_cmp #(.PWR_W(PWR_W)) u_cmp_main (
      .mclk(mclk),
      .nrst(nrst),
      .level(main_path_pwr),
      .thresh(thresh),
      .above_reg(main_ok)
   );
   opsel_cmp #(.PWR_W(PWR_W)) u_cmp_backup (
      .mclk(mclk),
      .nrst(nrst),
      .level(backup_path_pwr),
      .thresh(thresh),
      .above_reg(backup_ok)
   );

   // Selector decode
   wire logic pos_auto = sel_pos == `OPSEL_POS_AUTO;
   wire logic pos_left = sel_pos == `OPSEL_POS_LEFT;
   wire logic pos_right = sel_pos == `OPSEL_POS_RIGHT;
   wire logic on_backup = path_reg == opsel_pkg::OPSEL_ON_BACKUP;

   // Time main good while on backup
   opsel_timer #(.HOLD_CYC(REVERT_CYC)) u_revert (
      .mclk(mclk),
      .nrst(nrst),
      .run(main_ok && on_backup && pos_auto),
      .done_reg(revert_done)
   );

   // Next path selection
   always_comb begin
      path_next = path_reg;
      if (pos_left) begin
         path_next = opsel_pkg::OPSEL_ON_MAIN;
      end else if (pos_right) begin
         path_next = opsel_pkg::OPSEL_ON_BACKUP;
      end else if (pos_auto) begin
         unique case (path_reg)
            opsel_pkg::OPSEL_ON_MAIN: begin
               // Switch when main bad and backup good; else stay
               if (!main_ok && backup_ok) path_next = opsel_pkg::OPSEL_ON_BACKUP;
            end
            opsel_pkg::OPSEL_ON_BACKUP: begin
               if (revert_done) path_next = opsel_pkg::OPSEL_ON_MAIN;
            end
            default: path_next = opsel_pkg::OPSEL_ON_MAIN;
         endcase
      end
   end

   // Path state
   always_ff @(posedge mclk) begin
      if (!nrst) path_reg <= opsel_pkg::OPSEL_ON_MAIN;
      else path_reg <= path_next;
   end

   wire logic stat_red = switch_fail || temp_alarm || (!main_ok && !backup_ok);
   wire opsel_pkg::opsel_lamp_s stat_next = '{red: stat_red,
      yellow: !stat_red && on_backup, green: !stat_red && !on_backup};
   wire opsel_pkg::opsel_lamp_s main_next = '{red: !main_ok, yellow: 1'b0, green: main_ok};
   wire opsel_pkg::opsel_lamp_s backup_next = '{red: !backup_ok, yellow: 1'b0, green: backup_ok};

   // Indicator and readout registers
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         path_backup_reg <= 1'b0;
         stat_lamp_reg <= '0;
         main_lamp_reg <= '0;
         backup_lamp_reg <= '0;
         auto_lamp_reg <= 1'b0;
         main_pos_lamp_reg <= 1'b0;
         backup_pos_lamp_reg <= 1'b0;
         main_mon_reg <= '0;
         backup_mon_reg <= '0;
         thresh_mon_reg <= '0;
      end else begin
         path_backup_reg <= on_backup;
         stat_lamp_reg <= stat_next;
         main_lamp_reg <= main_next;
         backup_lamp_reg <= backup_next;
         auto_lamp_reg <= pos_auto;
         main_pos_lamp_reg <= !on_backup;
         backup_pos_lamp_reg <= on_backup;
         // Readouts in mV, 2000 means 0 dBm
         main_mon_reg <= main_path_pwr;
         backup_mon_reg <= backup_path_pwr;
         thresh_mon_reg <= thresh;
      end
   end
endmodule : opsel_top

// [test/opsel_front.sv]
// Detector and selector model
`timescale 1ns/100ps
module opsel_front (
   // Clock
   input wire logic mclk,
   // Wanted levels and selector position
   input wire logic [11:0] m_w,
   input wire logic [11:0] b_w,
   input wire logic [1:0] p_w,
   // Detector and selector outputs
   output logic [11:0] main_path_pwr = 12'h0,
   output logic [11:0] backup_path_pwr = 12'h0,
   output logic [1:0] sel_pos = 2'h0
);
   always @(negedge mclk) begin
      main_path_pwr <= m_w;
      backup_path_pwr <= b_w;
      sel_pos <= p_w;
   end
endmodule : opsel_front

// [test/opsel_props.sv]
// Port checker for the path selector
`timescale 1ns/100ps
module opsel_props (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Controls
   input wire logic [1:0] sel_pos,
   input wire logic switch_fail,
   input wire logic temp_alarm,
   // Outputs watched
   input wire logic path_backup_reg,
   input wire opsel_pkg::opsel_lamp_s stat_lamp_reg,
   input wire opsel_pkg::opsel_lamp_s main_lamp_reg,
   input wire logic auto_lamp_reg,
   input wire logic main_pos_lamp_reg,
   input wire logic backup_pos_lamp_reg
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   a_force_main: assert property ((sel_pos == 2'h1) [*2] |=> !path_backup_reg)
      else $error("forced main missed");
   a_force_backup: assert property ((sel_pos == 2'h2) [*2] |=> path_backup_reg)
      else $error("forced backup missed");
   a_auto_on: assert property ((sel_pos == 2'h0) [*3] |=> auto_lamp_reg)
      else $error("auto lamp dark");
   a_auto_off: assert property ((sel_pos != 2'h0) [*3] |=> !auto_lamp_reg)
      else $error("auto lamp lit");
   a_pos_main: assert property ($past(nrst) |-> main_pos_lamp_reg == !path_backup_reg)
      else $error("main position lamp wrong");
   a_pos_backup: assert property ($past(nrst) |-> backup_pos_lamp_reg == path_backup_reg)
      else $error("backup position lamp wrong");
   a_fault_red: assert property ((switch_fail || temp_alarm) [*2] |=> stat_lamp_reg.red)
      else $error("fault not red");
   a_stat_one: assert property ($past(nrst) |-> $onehot(stat_lamp_reg))
      else $error("status lamp not one colour");
   a_main_two: assert property ($past(nrst) |-> !main_lamp_reg.yellow && $onehot(main_lamp_reg))
      else $error("main lamp colour wrong");
   // Main scenarios reached
   c_to_backup: cover property ($rose(path_backup_reg));
   c_to_main: cover property ($fell(path_backup_reg));
   c_red: cover property (stat_lamp_reg.red);
endmodule : opsel_props
bind opsel_top opsel_props i_props (.mclk, .nrst, .sel_pos, .switch_fail, .temp_alarm, .path_backup_reg,
   .stat_lamp_reg, .main_lamp_reg, .auto_lamp_reg, .main_pos_lamp_reg, .backup_pos_lamp_reg);

// [test/tb.sv]
// Self-checking bench for the path selector
`timescale 1ns/100ps
module tb;
   localparam int RC = 20;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] m_w = 12'h7d1;
   logic [11:0] b_w = 12'h7d1;
   logic [1:0] p_w = 2'h0;
   logic [11:0] thresh_set = 12'h700;
   logic thresh_adjusted = 1'b0;
   logic switch_fail = 1'b0;
   logic temp_alarm = 1'b0;
   logic [11:0] main_path_pwr, backup_path_pwr, main_mon_reg, backup_mon_reg, thresh_mon_reg;
   logic [1:0] sel_pos;
   logic path_backup_reg, auto_lamp_reg, main_pos_lamp_reg, backup_pos_lamp_reg;
   opsel_pkg::opsel_lamp_s stat_lamp_reg, main_lamp_reg, backup_lamp_reg;
   int n_fail = 0;
   int n_compared = 0;
   initial forever #20 mclk = ~mclk;
   opsel_front i_front (.mclk, .m_w, .b_w, .p_w, .main_path_pwr, .backup_path_pwr, .sel_pos);
   opsel_top #(.REVERT_CYC(RC)) i_dut (.mclk, .nrst, .main_path_pwr, .backup_path_pwr, .thresh_set,
      .thresh_adjusted, .sel_pos, .switch_fail, .temp_alarm, .path_backup_reg, .stat_lamp_reg, .main_lamp_reg,
      .backup_lamp_reg, .auto_lamp_reg, .main_pos_lamp_reg, .backup_pos_lamp_reg, .main_mon_reg,
      .backup_mon_reg, .thresh_mon_reg);
   task automatic tally_and_finish();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Lamp colour compare
   task automatic chk_lamp(string nm, opsel_pkg::opsel_lamp_s e, opsel_pkg::opsel_lamp_s g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %b got %b", nm, e, g);
      end
   endtask : chk_lamp
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // Bounded wait for the switch drive
   task automatic wpath(logic e, int lim);
      for (int i = 0; i < lim && path_backup_reg !== e; i++) cyc(1);
      chk("path", 12'(e), 12'(path_backup_reg));
      if (path_backup_reg !== e) tally_and_finish();
   endtask : wpath
   initial begin
      cyc(12);
      nrst <= 1'b1;
      cyc(4);
      wpath(1'b0, 4);
      chk("tmon", 12'h7d0, thresh_mon_reg);
      chk_lamp("stat", 3'h1, stat_lamp_reg);
      m_w <= 12'h7d0;
      wpath(1'b1, 6);
      cyc(2);
      chk_lamp("stat", 3'h2, stat_lamp_reg);
      chk_lamp("mlamp", 3'h4, main_lamp_reg);
      chk("poslamps", 12'h2, 12'({backup_pos_lamp_reg, main_pos_lamp_reg}));
      m_w <= 12'h7d1;
      cyc(RC - 4);
      m_w <= 12'h7d0;
      cyc(1);
      m_w <= 12'h7d1;
      // Main good for just over the hold time: still on backup
      cyc(RC + 2);
      chk("path", 12'h1, 12'(path_backup_reg));
      wpath(1'b0, 4);
      m_w <= 12'h7d0;
      b_w <= 12'h7d0;
      cyc(6);
      chk("path", 12'h0, 12'(path_backup_reg));
      chk_lamp("stat", 3'h4, stat_lamp_reg);
      chk_lamp("blamp", 3'h4, backup_lamp_reg);
      thresh_adjusted <= 1'b1;
      cyc(5);
      chk_lamp("mlamp", 3'h1, main_lamp_reg);
      chk_lamp("blamp", 3'h1, backup_lamp_reg);
      chk("tmon", 12'h700, thresh_mon_reg);
      chk("mmon", 12'h7d0, main_mon_reg);
      chk("bmon", 12'h7d0, backup_mon_reg);
      p_w <= 2'h2;
      wpath(1'b1, 6);
      chk("auto", 12'h0, 12'(auto_lamp_reg));
      chk("poslamps", 12'h2, 12'({backup_pos_lamp_reg, main_pos_lamp_reg}));
      p_w <= 2'h1;
      wpath(1'b0, 6);
      p_w <= 2'h2;
      wpath(1'b1, 6);
      p_w <= 2'h0;
      cyc(4);
      chk("path", 12'h1, 12'(path_backup_reg));
      chk("auto", 12'h1, 12'(auto_lamp_reg));
      wpath(1'b0, RC + 10);
      switch_fail <= 1'b1;
      cyc(3);
      chk_lamp("stat", 3'h4, stat_lamp_reg);
      switch_fail <= 1'b0;
      temp_alarm <= 1'b1;
      cyc(3);
      chk_lamp("stat", 3'h4, stat_lamp_reg);
      tally_and_finish();
   end
endmodule : tb
